// File: irq_pkg.sv
// Purpose: shared constants for the pin request and vector priority block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: vector n sits at a two-byte slot below the top of memory
package irq_pkg;

  // Register byte offsets (low address byte)
  localparam logic [7:0] OFS_PIN_CTRL = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Field positions in the pin control word
  localparam int BIT_MODE = 0;
  localparam int BIT_IE = 1;
  localparam int BIT_ACK = 2;
  localparam int BIT_FLAG = 3;
  localparam int BIT_PE = 4;
  localparam int BIT_EDG = 5;

  // Field positions in the mask and status words
  localparam int BIT_GMASK = 0;
  localparam int STAT_VEC_LSB = 0;
  localparam int STAT_REQ_BIT = 8;
  localparam int STAT_LVL_BIT = 9;

  // Values after reset
  localparam logic CTRL_RST = 1'b0;
  localparam logic GMASK_RST = 1'b1;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // Vector numbering and slot layout
  localparam int NUM_VEC = 32;
  localparam int VEC_PERIPH_LO = 3;
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_SWI = 5'h01;
  localparam logic [4:0] VEC_PIN = 5'h02;
  localparam logic [15:0] VEC_TOP = 16'hFFFE;

  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Address of the high byte of vector n
  function automatic logic [15:0] vec_slot_addr(input logic [4:0] n);
    return VEC_TOP - {10'h000, n, 1'b0};
  endfunction

endpackage

// File: pin_irq_ctrl.sv
// Purpose: request pin detection, global mask and vector priority selection
// Assumes: AHB-Lite master issues single word transfers with IDLE data phases
// Notes: zero-wait slave, read data registered in the address phase
// Notes on behaviour
// - Pin detects events only while function enabled
// - Polarity bit picks asserted edge and level
// - Mode bit picks edge-only or edge-and-level
// - Local enable picks interrupt or polling only
// - Rising polarity swaps pullup for pulldown
// - Pin level offered to branch instructions
// - Deasserted-to-asserted transition sets the event flag
// - Level mode holds flag while pin asserted
// - Sources set flags; enabled ones reach core
// - Core acceptance stacks state and sets mask
// - Lowest vector number wins, reset first
// - Vector n slot at top minus 2n
// - High byte at lower address, low next
// - Polarity 0 falling/low, 1 rising/high
// - Write-only acknowledge clears the event flag
// - Global mask set after any reset
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
module pin_irq_ctrl (
  // Bus clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // External request pin and pad pulls
  input wire logic req_pin,
  output logic pull_up_en,
  output logic pull_down_en,
  // Other vector sources, already gated by their own enables
  input wire logic swi_req,
  input wire logic [irq_pkg::NUM_VEC-1:irq_pkg::VEC_PERIPH_LO] periph_req,
  // Core side
  input wire logic vec_ack,
  output logic pin_level,
  output logic int_req,
  output logic int_mask,
  output logic [4:0] vec_num,
  output logic [15:0] vec_addr_hi,
  output logic [15:0] vec_addr_lo
);
  import irq_pkg::*;

  logic take;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_rdata;
  logic pe_ff;
  logic edg_ff;
  logic mode_ff;
  logic ie_ff;
  logic flag_ff;
  logic mask_ff;
  logic boot_ff;
  logic pin_s;
  logic asserted;
  logic prev_asr_ff;
  logic set_evt;
  logic ack_wr;
  logic mask_wr;
  logic ctrl_wr;
  logic pin_req;
  logic [NUM_VEC-1:0] pend;
  logic sel_valid;
  logic [4:0] sel_num;
  logic int_req_ff;
  logic [4:0] vec_num_ff;
  logic pin_level_ff;
  logic pull_up_ff;
  logic pull_down_ff;

  // Pin synchroniser, detection only looks at its second stage
  pin_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_raw(req_pin),
    .pin_sync_out(pin_s)
  );

  // Address phase acceptance; only whole words are honoured
  assign take = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);

  // Write address latched for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end
    else
    begin
      wr_pend_ff <= take & hwrite;
      wr_addr_ff <= haddr[7:0];
    end
  end

  // Data phase write strobes
  assign ctrl_wr = wr_pend_ff & (wr_addr_ff == OFS_PIN_CTRL);
  assign mask_wr = wr_pend_ff & (wr_addr_ff == OFS_MASK);
  assign ack_wr = ctrl_wr & hwdata[BIT_ACK];

  // Read mux; unmapped offsets read zero, acknowledge reads zero
  always_comb
  begin
    nxt_rdata = RDATA_RST;
    unique case (haddr[7:0])
      OFS_PIN_CTRL:
      begin
        nxt_rdata[BIT_MODE] = mode_ff;
        nxt_rdata[BIT_IE] = ie_ff;
        nxt_rdata[BIT_FLAG] = flag_ff;
        nxt_rdata[BIT_PE] = pe_ff;
        nxt_rdata[BIT_EDG] = edg_ff;
      end
      OFS_MASK:
      begin
        nxt_rdata[BIT_GMASK] = mask_ff;
      end
      OFS_STATUS:
      begin
        nxt_rdata[STAT_VEC_LSB +: 5] = vec_num_ff;
        nxt_rdata[STAT_REQ_BIT] = int_req_ff;
        nxt_rdata[STAT_LVL_BIT] = pin_level_ff;
      end
      default:
      begin
        nxt_rdata = RDATA_RST;
      end
    endcase
  end

  // Read data captured at the address phase edge, stands in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_ff <= RDATA_RST;
    end
    else if (take & ~hwrite)
    begin
      hrdata_ff <= nxt_rdata;
    end
  end

  // Zero-wait slave, never an error
  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Pin configuration bits written by software
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pe_ff <= CTRL_RST;
      edg_ff <= CTRL_RST;
      mode_ff <= CTRL_RST;
      ie_ff <= CTRL_RST;
    end
    else if (ctrl_wr)
    begin
      pe_ff <= hwdata[BIT_PE];
      edg_ff <= hwdata[BIT_EDG];
      mode_ff <= hwdata[BIT_MODE];
      ie_ff <= hwdata[BIT_IE];
    end
  end

  // Asserted sense: 0 means low/falling, 1 means high/rising
  assign asserted = edg_ff ? pin_s : ~pin_s;

  // Previous asserted state; a polarity change may look like an edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_asr_ff <= 1'b0;
    end
    else
    begin
      prev_asr_ff <= asserted;
    end
  end

  // Edge always counts; level also counts in edge-and-level mode
  assign set_evt = pe_ff & asserted & (~prev_asr_ff | mode_ff);

  // Event flag; a set in the same cycle as the acknowledge wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flag_ff <= 1'b0;
    end
    else if (set_evt)
    begin
      flag_ff <= 1'b1;
    end
    else if (ack_wr)
    begin
      flag_ff <= 1'b0;
    end
  end

  // Only an enabled flag goes forward; otherwise it is left for polling
  assign pin_req = flag_ff & ie_ff;

  // Global mask: set by reset and by core acceptance, else software
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mask_ff <= GMASK_RST;
    end
    else if (vec_ack)
    begin
      mask_ff <= 1'b1;
    end
    else if (mask_wr)
    begin
      mask_ff <= hwdata[BIT_GMASK];
    end
  end

  // Reset vector stays pending until the core takes its first vector
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      boot_ff <= 1'b1;
    end
    else if (vec_ack)
    begin
      boot_ff <= 1'b0;
    end
  end

  // Pending word: maskable sources gated by the global mask
  assign pend = {periph_req & {(NUM_VEC - VEC_PERIPH_LO){~mask_ff}},
                 pin_req & ~mask_ff, swi_req, boot_ff};

  vector_select u_sel (
    .pend(pend),
    .sel_valid(sel_valid),
    .sel_num(sel_num)
  );

  // Request and vector registered toward the core
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      int_req_ff <= 1'b0;
      vec_num_ff <= VEC_RESET;
    end
    else
    begin
      int_req_ff <= sel_valid;
      vec_num_ff <= sel_num;
    end
  end

  assign int_req = int_req_ff;
  assign int_mask = mask_ff;
  assign vec_num = vec_num_ff;
  // High byte at the slot base, low byte one above
  assign vec_addr_hi = vec_slot_addr(vec_num_ff);
  assign vec_addr_lo = vec_addr_hi + 16'h0001;

  // Pin level for branch tests and pad pull choice
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_level_ff <= 1'b1;
      pull_up_ff <= 1'b0;
      pull_down_ff <= 1'b0;
    end
    else
    begin
      pin_level_ff <= pe_ff ? pin_s : 1'b1;
      pull_up_ff <= pe_ff & ~edg_ff;
      pull_down_ff <= pe_ff & edg_ff;
    end
  end

  assign pin_level = pin_level_ff;
  assign pull_up_en = pull_up_ff;
  assign pull_down_en = pull_down_ff;

  // Checks on the detection path
  a_flag_on_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    pe_ff && asserted && !prev_asr_ff |=> flag_ff)
    else $error("edge did not set event flag");

  a_level_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    pe_ff && mode_ff && asserted && ack_wr |=> flag_ff)
    else $error("flag cleared while level asserted");

  a_no_event_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !pe_ff && !flag_ff |=> !flag_ff)
    else $error("flag set while pin disabled");

  a_low_sense: assert property (@(posedge hclk) disable iff (!hresetn)
    pe_ff && !edg_ff && !pin_s && $past(pin_s) && $stable(edg_ff) |=> flag_ff)
    else $error("falling edge missed at polarity 0");

  a_pull_select: assert property (@(posedge hclk) disable iff (!hresetn)
    pe_ff && edg_ff ##1 $stable(pe_ff) && $stable(edg_ff) |-> pull_down_en && !pull_up_en)
    else $error("pulldown not chosen for rising sense");

  // Checks on mask and vector delivery
  a_mask_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> int_mask && vec_num == VEC_RESET)
    else $error("mask clear after reset");

  a_mask_on_ack: assert property (@(posedge hclk) disable iff (!hresetn)
    vec_ack |=> int_mask && !boot_ff)
    else $error("mask not set on acceptance");

  a_pin_vector: assert property (@(posedge hclk) disable iff (!hresetn)
    flag_ff && ie_ff && !mask_ff && !swi_req && !boot_ff
    |=> int_req && vec_num == VEC_PIN && vec_addr_hi == 16'hFFFA)
    else $error("pin vector not presented");

  a_no_forward: assert property (@(posedge hclk) disable iff (!hresetn)
    !ie_ff && !boot_ff && !swi_req && (mask_ff || periph_req == '0) |=> !int_req)
    else $error("request forwarded without enable");

  a_slot_pair: assert property (@(posedge hclk) disable iff (!hresetn)
    vec_num == VEC_SWI |-> vec_addr_hi == 16'hFFFC && vec_addr_lo == 16'hFFFD)
    else $error("vector slot bytes misplaced");

  // Main scenarios
  c_pin_irq: cover property (@(posedge hclk) disable iff (!hresetn)
    int_req && vec_num == VEC_PIN ##1 vec_ack);
  c_level_ack: cover property (@(posedge hclk) disable iff (!hresetn)
    mode_ff && ack_wr && asserted);
  c_poll_only: cover property (@(posedge hclk) disable iff (!hresetn)
    flag_ff && !ie_ff && !mask_ff);

endmodule

// File: pin_irq_ctrl_tb.sv
// Purpose: self-checking bench for pin detection and vector priority
// Assumes: zero-wait bus slave, hready looped from hreadyout
// Notes: random sources from a fixed seed, corners mixed in
module pin_irq_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import irq_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic swi_req = 1'b0;
  logic vec_ack = 1'b0;
  logic drv = 1'b1;
  logic lvl = 1'b1;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [NUM_VEC-1:VEC_PERIPH_LO] periph_req = '0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout, hresp, req_pin, pu, pd, pin_level, int_req, int_mask;
  logic [4:0] vec_num;
  logic [15:0] va_hi, va_lo;
  logic [5:0] e;
  int mismatches = 0;
  int n_compared = 0;
  int lag = 3;
  integer seed = 41;

  // Bus clock
  always #5 hclk = ~hclk;

  pin_irq_ctrl pin_irq_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .req_pin(req_pin), .pull_up_en(pu), .pull_down_en(pd), .swi_req(swi_req),
    .periph_req(periph_req), .vec_ack(vec_ack), .pin_level(pin_level),
    .int_req(int_req), .int_mask(int_mask), .vec_num(vec_num),
    .vec_addr_hi(va_hi), .vec_addr_lo(va_lo));

  req_pin_dev req_pin_dev_inst (.drive_en(drv), .level(lvl), .lag_ns(lag),
    .pull_up_en(pu), .pull_down_en(pd), .req_pin(req_pin));

  // Comparisons
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (exp !== got)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task chb(input string what, input logic exp, input logic got);
    chk(what, {15'h0000, exp}, {15'h0000, got});
  endtask

  // One single AHB transfer; read data lands in rd
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chb("hresp", 1'b0, hresp);
    hsel <= 1'b0;
  endtask

  // Let updates land after n edges
  task settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // Pin control word
  function automatic logic [31:0] ctl(input logic pe, edg, mode, ie, ack);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[BIT_PE] = pe;
    v[BIT_EDG] = edg;
    v[BIT_MODE] = mode;
    v[BIT_IE] = ie;
    v[BIT_ACK] = ack;
    return v;
  endfunction

  // Expected {valid, vector}: lowest pending number wins
  function automatic logic [5:0] exp_vec(input logic sw, input logic [31:3] p, input logic m);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 31; i >= 3; i--)
      if (p[i] && !m)
        r = {1'b1, i[4:0]};
    if (sw)
      r = 6'h21;
    return r;
  endfunction

  task flag(input logic exp);
    bus(1'b0, OFS_PIN_CTRL, 32'h0000_0000);
    chb("pin_event_flag", exp, rd[BIT_FLAG]);
  endtask

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog far beyond the expected run length
  initial
  begin
    #300000;
    mismatches++;
    test_done();
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    settle(2);
    chb("int_mask", 1'b1, int_mask);
    chb("int_req", 1'b1, int_req);
    chk("vec_num", 16'h0000, {11'h000, vec_num});
    chk("vec_addr_hi", 16'hFFFE, va_hi);
    chk("vec_addr_lo", 16'hFFFF, va_lo);
    bus(1'b0, OFS_MASK, 32'h0000_0000);
    chb("mask reg", 1'b1, rd[BIT_GMASK]);
    bus(1'b0, 8'h0C, 32'h0000_0000);
    chk("unmapped", 16'h0000, rd[15:0]);
    @(posedge hclk);
    vec_ack <= 1'b1;
    @(posedge hclk);
    vec_ack <= 1'b0;
    settle(2);
    chb("int_req after ack", 1'b0, int_req);
    chb("int_mask after ack", 1'b1, int_mask);
    bus(1'b1, OFS_MASK, 32'h0000_0000);
    // Disabled pin sees nothing
    lvl <= 1'b0;
    settle(6);
    flag(1'b0);
    chb("pin_level off", 1'b1, pin_level);
    lvl <= 1'b1;
    bus(1'b1, OFS_PIN_CTRL, ctl(1'b1, 1'b0, 1'b0, 1'b1, 1'b0));
    settle(4);
    chb("pull_up_en", 1'b1, pu);
    chb("pull_down_en", 1'b0, pd);
    // Falling edge, edge-only mode
    lvl <= 1'b0;
    settle(6);
    chb("pin_level", 1'b0, pin_level);
    chb("int_req pin", 1'b1, int_req);
    chk("vec_num pin", 16'h0002, {11'h000, vec_num});
    chk("pin hi", 16'hFFFA, va_hi);
    chk("pin lo", 16'hFFFB, va_lo);
    // Status word: vector 2, request up, pin low
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("status", 16'h0102, rd[15:0]);
    // Core takes the pin vector; mask then hides the still-set flag
    @(posedge hclk);
    vec_ack <= 1'b1;
    @(posedge hclk);
    vec_ack <= 1'b0;
    settle(2);
    chb("int_mask pin ack", 1'b1, int_mask);
    chb("int_req pin ack", 1'b0, int_req);
    bus(1'b1, OFS_MASK, 32'h0000_0000);
    flag(1'b1);
    bus(1'b1, OFS_PIN_CTRL, ctl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1));
    flag(1'b0);
    // Level mode holds the flag while asserted
    lvl <= 1'b1;
    bus(1'b1, OFS_PIN_CTRL, ctl(1'b1, 1'b0, 1'b1, 1'b1, 1'b1));
    lvl <= 1'b0;
    settle(6);
    bus(1'b1, OFS_PIN_CTRL, ctl(1'b1, 1'b0, 1'b1, 1'b1, 1'b1));
    flag(1'b1);
    lvl <= 1'b1;
    settle(6);
    bus(1'b1, OFS_PIN_CTRL, ctl(1'b1, 1'b0, 1'b1, 1'b1, 1'b1));
    flag(1'b0);
    // Rising polarity, slow device
    lag = 7;
    lvl <= 1'b0;
    settle(4);
    bus(1'b1, OFS_PIN_CTRL, ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b1));
    bus(1'b1, OFS_PIN_CTRL, ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b1));
    chb("pull_down_en rise", 1'b1, pd);
    chb("pull_up_en rise", 1'b0, pu);
    lvl <= 1'b1;
    settle(6);
    flag(1'b1);
    chb("int_req polled", 1'b0, int_req);
    bus(1'b1, OFS_PIN_CTRL, ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b1));
    flag(1'b0);
    drv <= 1'b0;
    // Priority over random and corner source sets
    for (int m = 0; m < 2; m++)
    begin
      bus(1'b1, OFS_MASK, {31'h0000_0000, m[0]});
      for (int i = 0; i < 20; i++)
      begin
        @(posedge hclk);
        swi_req <= (i > 2) ? 1'($random(seed)) : 1'b0;
        periph_req <= (i == 0) ? '0 : (i == 1) ? '1 : (i == 2) ? 29'h1000_0000 :
          29'($random(seed));
        settle(3);
        e = exp_vec(swi_req, periph_req, m[0]);
        chb("int_req prio", e[5], int_req);
        if (e[5])
        begin
          chk("vec_num prio", {11'h000, e[4:0]}, {11'h000, vec_num});
          chk("slot hi", 16'hFFFE - {10'h000, e[4:0], 1'b0}, va_hi);
          chk("slot lo", 16'hFFFF - {10'h000, e[4:0], 1'b0}, va_lo);
        end
      end
    end
    // Reset in mid-run sets the mask again
    hresetn <= 1'b0;
    settle(2);
    hresetn <= 1'b1;
    settle(2);
    chb("int_mask rerst", 1'b1, int_mask);
    chk("vec_num rerst", 16'h0000, {11'h000, vec_num});
    test_done();
  end
endmodule

// File: pin_sync.sv
// Purpose: two-stage synchroniser for the external request pin
// Assumes: pin is asynchronous to hclk
// Notes: only the second stage may be read by other logic
module pin_sync (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Raw and synchronised level
  input wire logic pin_raw,
  output logic pin_sync_out
);

  logic meta_ff;
  logic sync_ff;

  // Two flops in series, nothing taps the first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= pin_raw;
      sync_ff <= meta_ff;
    end
  end

  assign pin_sync_out = sync_ff;

endmodule

// File: req_pin_dev.sv
// Purpose: external device that drives the request pin
// Assumes: pin changes land lag_ns after each stimulus change, clear of the hclk edge
// Notes: a released pin follows the pad pull, else it drifts
module req_pin_dev (
  // Stimulus from the bench
  input wire logic drive_en,
  input wire logic level,
  input wire integer lag_ns,
  // Pad pulls chosen by the block
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  // Request pin
  output logic req_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req_pin = 1'b1;
  // Lag keeps pin moves away from the clock edge, prompt or slow
  always
  begin
    @(drive_en or level or pull_up_en or pull_down_en);
    #(lag_ns);
    if (drive_en)
      req_pin = level;
    else if (pull_up_en)
      req_pin = 1'b1;
    else if (pull_down_en)
      req_pin = 1'b0;
    else
      req_pin = ~req_pin; // Floating: never hold the last value
  end
endmodule

// File: vector_select.sv
// Purpose: fixed-priority pick of the lowest pending vector number
// Assumes: bit n of the request word is vector n
// Notes: vector 0 wins over all others
module vector_select (
  // Pending requests, one bit per vector
  input wire logic [irq_pkg::NUM_VEC-1:0] pend,
  // Selected vector
  output logic sel_valid,
  output logic [4:0] sel_num
);
  import irq_pkg::*;

  // Scan from the top so the lowest set bit is the last to win
  function automatic logic [4:0] lowest_set(input logic [NUM_VEC-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NUM_VEC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Lower number means higher priority
  assign sel_valid = |pend;
  assign sel_num = lowest_set(pend);

endmodule
